//--- core/stp_chop.v
// Purpose: chopper phase sequencer driven by the chopper word fields
// Assumes: comparator inputs already synchronised to sys_clk
// Notes: hysteresis shaping itself lies outside; only its decrement tick
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.vh"

module stp_chop (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire [1:0] blank_time,
	input  wire       chopper_mode_select,
	input  wire       random_off_time,
	input  wire [1:0] hyst_decrement_sel,
	input  wire [2:0] hyst_start_value,
	input  wire [3:0] slow_decay_time,
	input  wire       peak_hit,
	input  wire       neg_hit,
	output reg        bridge_on,
	output reg        fast_decay,
	output reg        slow_decay,
	output reg        blank_active,
	output reg        hyst_dec_tick
);

	localparam ST_OFF  = 2'b00;
	localparam ST_ON   = 2'b01;
	localparam ST_FAST = 2'b10;
	localparam ST_SLOW = 2'b11;

	reg [1:0] state;
	reg [9:0] cnt;
	reg [5:0] blank_cnt;
	reg [6:0] dec_cnt;
	reg [7:0] lfsr;
	reg [5:0] blank_len;
	reg [6:0] dec_len;
	reg [9:0] off_len;
	reg [9:0] fast_len;
	wire      comp_ends;

	// ============================================================
	// interval decode
	always @* begin
		case (blank_time) // R7
		2'b00:   blank_len = `STP_BLANK_0;
		2'b01:   blank_len = `STP_BLANK_1;
		2'b10:   blank_len = `STP_BLANK_2;
		default: blank_len = `STP_BLANK_3;
		endcase
		case (hyst_decrement_sel) // R11
		2'b00:   dec_len = `STP_DEC_0;
		2'b01:   dec_len = `STP_DEC_1;
		2'b10:   dec_len = `STP_DEC_2;
		default: dec_len = `STP_DEC_3;
		endcase
		off_len = `STP_OFF_BASE + {1'b0, slow_decay_time, 5'h00};
		// jitter of -12..+3 clocks keeps the chopper off a fixed tone
		if (random_off_time) // R10
			off_len = off_len + {6'h00, lfsr[3:0]} - `STP_RND_SHIFT;
		fast_len = {1'b0, hyst_decrement_sel[0], hyst_start_value, 5'h00};
	end

	// with the upper decrement bit set only the timer ends fast decay
	assign comp_ends = !hyst_decrement_sel[1] && neg_hit; // R12 R13

	// ============================================================
	// phase sequencer
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state     <= ST_OFF;
			cnt       <= 10'h000;
			blank_cnt <= 6'h00;
			lfsr      <= 8'hA5;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			if (blank_cnt != 6'h00)
				blank_cnt <= blank_cnt - 6'h01;
			if (slow_decay_time == 4'h0) begin
				state <= ST_OFF;
			end else begin
				case (state)
				ST_OFF: begin
					state     <= ST_ON;
					blank_cnt <= blank_len;
				end
				ST_ON: begin
					if (blank_cnt == 6'h00 && peak_hit) begin
						if (chopper_mode_select && fast_len != 10'h000) begin
							state <= ST_FAST; // R8 R9
							cnt   <= fast_len;
						end else begin
							state <= ST_SLOW;
							cnt   <= off_len;
						end
					end
				end
				ST_FAST: begin
					if (cnt <= 10'h001 || comp_ends) begin // R9 R12 R13
						state <= ST_SLOW;
						cnt   <= off_len;
					end else begin
						cnt <= cnt - 10'h001;
					end
				end
				default: begin
					if (cnt <= 10'h001) begin
						state     <= ST_ON;
						blank_cnt <= blank_len;
					end else begin
						cnt <= cnt - 10'h001;
					end
				end
				endcase
			end
		end
	end

	// ============================================================
	// decrement tick and registered outputs
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			dec_cnt       <= 7'h00;
			hyst_dec_tick <= 1'b0;
			bridge_on     <= 1'b0;
			fast_decay    <= 1'b0;
			slow_decay    <= 1'b0;
			blank_active  <= 1'b0;
		end else begin
			hyst_dec_tick <= 1'b0;
			if (chopper_mode_select || state == ST_OFF) begin
				dec_cnt <= 7'h00;
			end else if (dec_cnt + 7'h01 >= dec_len) begin
				dec_cnt       <= 7'h00;
				hyst_dec_tick <= 1'b1; // R11
			end else begin
				dec_cnt <= dec_cnt + 7'h01;
			end
			bridge_on    <= state == ST_ON;
			fast_decay   <= state == ST_FAST;
			slow_decay   <= state == ST_SLOW;
			blank_active <= state == ST_ON && blank_cnt != 6'h00;
		end
	end

endmodule
`default_nettype wire

//--- core/stp_drv.v
// Purpose: serial configuration, step decoding and chopper control
// Assumes: all pins asynchronous to sys_clk, sys_clk far faster than sck
// Notes: write-only words; a word takes effect when chip select rises
//
// Summary of operation
// R1: with serial direct-current mode clear, the step/dir inputs are live.
// R2: words with bits 19 and 18 zero load the driver control word.
// R3: interpolation bit 9 turns each step into 16 sub-steps.
// R4: double-edge bit 8 makes both step edges advance position.
// R5: resolution 0 gives 256 microsteps per quarter, halving to 1 at 8.
// R6: words with bits 19..17 equal 100 load the chopper word.
// R7: blanking codes give 16, 24, 36 or 54 clocks.
// R8: mode bit 14 picks hysteresis or constant off-time chopping.
// R9: constant off-time fast decay follows on phase, ends at negative peak.
// R10: random bit 13 jitters the slow decay time by a few clocks.
// R11: standard mode decrement codes give 16, 32, 48 or 64 clocks.
// R12: upper decrement bit clear lets comparator end fast decay.
// R13: upper decrement bit set lets only the timer end fast decay.
// R14: controller writes zeros into reserved driver control bits.
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.vh"

module stp_drv #(
	parameter INTERP_GAP = 8
) (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       spi_sck,
	input  wire       spi_cs_n,
	input  wire       spi_sdi,
	input  wire       step_in,
	input  wire       dir_in,
	input  wire       peak_in,
	input  wire       neg_in,
	output wire       step_mode_active,
	output wire       step_interp_enable,
	output wire       double_edge_step,
	output wire [3:0] microstep_resolution,
	output reg  [9:0] ustep_pos,
	output reg        ustep_evt,
	output wire       chopper_mode_select,
	output wire       bridge_on,
	output wire       fast_decay,
	output wire       slow_decay,
	output wire       blank_active,
	output wire       hyst_dec_tick
);

	// ============================================================
	// pin synchronisers
	// order: sck, cs_n, sdi, step, dir, peak, neg
	reg [6:0] pin_s1;
	reg [6:0] pin_s2;
	reg [6:0] pin_d;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_s1 <= 7'h02;
			pin_s2 <= 7'h02;
			pin_d  <= 7'h02;
		end else begin
			pin_s1 <= {neg_in, peak_in, dir_in, step_in,
				spi_sdi, spi_cs_n, spi_sck};
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
		end
	end

	wire sck_rise  = pin_s2[0] && !pin_d[0];
	wire cs_low    = !pin_s2[1];
	wire cs_rise   = pin_s2[1] && !pin_d[1];
	wire sdi_s     = pin_s2[2];
	wire step_s    = pin_s2[3];
	wire step_prev = pin_d[3];
	wire dir_s     = pin_s2[4];
	wire peak_s    = pin_s2[5];
	wire neg_s     = pin_s2[6];

	// ============================================================
	// serial receiver
	// longer frames keep the last 20 bits; shorter ones are dropped
	reg [19:0] shift;
	reg [4:0]  bit_cnt;
	reg [19:0] driver_control_word;
	reg [19:0] chopper_config_word;
	// held inverted so the mode output leaves a flip-flop directly
	reg        step_mode_on;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			shift   <= 20'h00000;
			bit_cnt <= 5'h00;
		end else if (cs_low && sck_rise) begin
			shift <= {shift[18:0], sdi_s};
			if (bit_cnt != `STP_WORD_W)
				bit_cnt <= bit_cnt + 5'h01;
		end else if (!cs_low) begin
			bit_cnt <= 5'h00;
		end
	end

	wire word_done = cs_rise && bit_cnt == `STP_WORD_W;

	// ============================================================
	// register decode
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			driver_control_word        <= `STP_DRV_RST;
			chopper_config_word        <= `STP_CHOP_RST;
			step_mode_on               <= !`STP_SERIAL_DIRECT_CURRENT_MODE_RST;
		end else if (word_done) begin
			if (shift[19:18] == `STP_ADDR_DRV)
				driver_control_word <= shift; // R2
			if (shift[19:17] == `STP_ADDR_CHOP)
				chopper_config_word <= shift; // R6
			if (shift[19:17] == `STP_ADDR_DCONF)
				step_mode_on <= !shift[`STP_SERIAL_DIRECT_CURRENT_MODE_BIT]; // R1
		end
	end

	// reserved bits are stored as written; the controller keeps them zero
	// R14
	assign step_mode_active     = step_mode_on; // R1
	assign step_interp_enable   = driver_control_word[`STP_INTERP_BIT];
	assign double_edge_step     = driver_control_word[`STP_DOUBLE_EDGE_STEP_BIT];
	assign microstep_resolution =
		driver_control_word[`STP_MICROSTEP_RESOLUTION_HI:`STP_MICROSTEP_RESOLUTION_LO];
	assign chopper_mode_select  = chopper_config_word[`STP_CHM_BIT];

	// ============================================================
	// step edge decode
	reg step_evt;

	always @(posedge sys_clk) begin
		if (!rst_n)
			step_evt <= 1'b0;
		else if (!step_mode_active)
			step_evt <= 1'b0; // R1
		else if (double_edge_step)
			step_evt <= step_s != step_prev; // R4
		else
			step_evt <= step_s && !step_prev; // R4
	end

	wire sub_evt;

	stp_interp #(
		.GAP (INTERP_GAP)
	) u_interp (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.step_evt  (step_evt),
		.interp_en (step_interp_enable),
		.sub_evt   (sub_evt)
	);

	// ============================================================
	// microstep position
	// table position counts 1024 per electrical period
	function [9:0] step_inc;
		input [3:0] res;
		input       interp;
		reg   [3:0] r;
		reg   [9:0] full;
		begin
			r = (res > `STP_FULLSTEP) ? `STP_FULLSTEP : res;
			full = 10'h001 << r; // R5
			if (interp && full > 10'h00F)
				step_inc = full >> 4; // R3
			else
				step_inc = interp ? 10'h001 : full;
		end
	endfunction

	// position moves by the grid step from its current value; it is not aligned to the chosen grid
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ustep_pos <= 10'h000;
			ustep_evt <= 1'b0;
		end else begin
			ustep_evt <= sub_evt;
			if (sub_evt) begin
				if (dir_s)
					ustep_pos <= ustep_pos - step_inc(
						microstep_resolution, step_interp_enable);
				else
					ustep_pos <= ustep_pos + step_inc(
						microstep_resolution, step_interp_enable);
			end
		end
	end

	// ============================================================
	// chopper
	stp_chop u_chop (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.blank_time          (chopper_config_word[`STP_TBL_HI:`STP_TBL_LO]),
		.chopper_mode_select (chopper_mode_select),
		.random_off_time     (chopper_config_word[`STP_RND_BIT]),
		.hyst_decrement_sel  (
			chopper_config_word[`STP_HYST_DECREMENT_SEL_HI:`STP_HYST_DECREMENT_SEL_LO]),
		.hyst_start_value    (
			chopper_config_word[`STP_HYST_START_VALUE_HI:`STP_HYST_START_VALUE_LO]),
		.slow_decay_time     (
			chopper_config_word[`STP_SLOW_DECAY_TIME_HI:`STP_SLOW_DECAY_TIME_LO]),
		.peak_hit            (peak_s),
		.neg_hit             (neg_s),
		.bridge_on           (bridge_on),
		.fast_decay          (fast_decay),
		.slow_decay          (slow_decay),
		.blank_active        (blank_active),
		.hyst_dec_tick       (hyst_dec_tick)
	);

endmodule
`default_nettype wire

//--- core/stp_interp.v
// Purpose: multiplies each step event into a burst of sub-steps
// Assumes: step events are one-cycle pulses on sys_clk
// Notes: a new step restarts the burst; unfinished sub-steps are dropped
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.vh"

module stp_interp #(
	parameter GAP = 8
) (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       step_evt,
	input  wire       interp_en,
	output reg        sub_evt
);

	// ============================================================
	// burst counter
	reg [4:0]  remaining;
	reg [15:0] gap_cnt;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			remaining <= 5'h00;
			gap_cnt   <= 16'h0000;
			sub_evt   <= 1'b0;
		end else if (step_evt && !interp_en) begin
			remaining <= 5'h00;
			sub_evt   <= 1'b1; // R3
		end else if (step_evt) begin
			// first sub-step at once, then one every GAP cycles
			remaining <= `STP_INTERP_N - 5'h01; // R3
			gap_cnt   <= GAP[15:0];
			sub_evt   <= 1'b1;
		end else if (remaining != 5'h00 && gap_cnt <= 16'h0001) begin
			remaining <= remaining - 5'h01;
			gap_cnt   <= GAP[15:0];
			sub_evt   <= 1'b1;
		end else begin
			if (gap_cnt != 16'h0000)
				gap_cnt <= gap_cnt - 16'h0001;
			sub_evt <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- core/stp_map.vh
// Purpose: constants for the step/dir and chopper configuration block
// Assumes: 20-bit serial words, MSB first, addressed by their top bits
// Notes: timing counts are in system clock periods
`ifndef STP_MAP_VH
`define STP_MAP_VH

// ============================================================
// word layout
`define STP_WORD_W      20
`define STP_ADDR_DRV    2'b00
`define STP_ADDR_CHOP   3'b100
`define STP_ADDR_DCONF  3'b111
`define STP_SERIAL_DIRECT_CURRENT_MODE_BIT   7
`define STP_INTERP_BIT  9
`define STP_DOUBLE_EDGE_STEP_BIT   8
`define STP_MICROSTEP_RESOLUTION_HI     3
`define STP_MICROSTEP_RESOLUTION_LO     0
`define STP_TBL_HI      16
`define STP_TBL_LO      15
`define STP_CHM_BIT     14
`define STP_RND_BIT     13
`define STP_HYST_DECREMENT_SEL_HI     12
`define STP_HYST_DECREMENT_SEL_LO     11
`define STP_HYST_START_VALUE_HI    6
`define STP_HYST_START_VALUE_LO    4
`define STP_SLOW_DECAY_TIME_HI     3
`define STP_SLOW_DECAY_TIME_LO     0

// ============================================================
// reset values
`define STP_DRV_RST     20'h00000
`define STP_CHOP_RST    20'h00000
`define STP_SERIAL_DIRECT_CURRENT_MODE_RST   1'b0

// ============================================================
// timing counts
`define STP_BLANK_0     6'h10
`define STP_BLANK_1     6'h18
`define STP_BLANK_2     6'h24
`define STP_BLANK_3     6'h36
`define STP_DEC_0       7'h10
`define STP_DEC_1       7'h20
`define STP_DEC_2       7'h30
`define STP_DEC_3       7'h40
`define STP_OFF_BASE    10'h00C
`define STP_RND_SHIFT   10'h00C
`define STP_INTERP_N    5'h10
`define STP_FULLSTEP    4'h8

`endif

//--- sim/stp_ctl_model.sv
// Purpose: motion controller driving serial words and step pins
// Assumes: pins change 1 ns after a sys_clk rise
// Notes: sck rests low between frames
`timescale 1ns/1ps
`default_nettype none
module stp_ctl_model (
	input  wire logic sys_clk,
	output var logic  spi_sck,
	output var logic  spi_cs_n,
	output var logic  spi_sdi,
	output var logic  step_in,
	output var logic  dir_in
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
		step_in = 1'b0;
		dir_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// ==========================================================
	// address bits travel first, so routing is set by the caller
	task automatic send(input logic [19:0] w);
		for (int i = 19; i >= 0; i--) begin
			spi_cs_n = 1'b0;
			spi_sdi = w[i];
			tick(4);
			spi_sck = 1'b1;
			tick(4);
			spi_sck = 1'b0;
		end
		tick(4);
		spi_cs_n = 1'b1;
		// released line must not keep the last bit
		spi_sdi = ~spi_sdi;
		tick(8);
	endtask
	// dir settles 4 cycles ahead of the edge
	task automatic pulse(input logic d, input int n);
		dir_in = d;
		tick(4);
		step_in = ~step_in;
		tick(n);
	endtask
endmodule
`default_nettype wire

//--- sim/stp_drv_props.sv
// Purpose: port assertions for stp_drv
// Assumes: one clock, synchronous active-low reset
// Notes: sub-step spacing follows INTERP_GAP
`timescale 1ns/1ps
`default_nettype none
module stp_drv_props #(
	parameter INTERP_GAP = 8
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       step_in,
	input wire logic       dir_in,
	input wire logic       step_mode_active,
	input wire logic       step_interp_enable,
	input wire logic       double_edge_step,
	input wire logic [3:0] microstep_resolution,
	input wire logic [9:0] ustep_pos,
	input wire logic       ustep_evt,
	input wire logic       chopper_mode_select,
	input wire logic       bridge_on,
	input wire logic       fast_decay,
	input wire logic       slow_decay,
	input wire logic       blank_active
);
	localparam int G = INTERP_GAP;
	logic [6:0] blen;
	logic [9:0] inc;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// helpers; codes above 8 act as full step
	assign inc = 10'h001 << ((microstep_resolution > 4'h8) ? 4'h8
		: microstep_resolution);
	always @(posedge sys_clk)
		blen <= blank_active ? blen + 7'h01 : 7'h00;
	// ==========================================================
	// properties
	property p_hot;
		$onehot0({bridge_on, fast_decay, slow_decay});
	endproperty
	a_hot: assert property (p_hot) else $error("phases overlap");
	property p_rise;
		$rose(step_in) && step_mode_active && !step_interp_enable
			|-> ##[3:6] ustep_evt;
	endproperty
	a_rise: assert property (p_rise) else $error("step lost");
	property p_single;
		$fell(step_in) && !double_edge_step && !step_interp_enable
			|-> ##3 !ustep_evt [*4];
	endproperty
	a_single: assert property (p_single) else $error("fall moved");
	property p_double;
		$fell(step_in) && double_edge_step && step_mode_active &&
			!step_interp_enable |-> ##[3:6] ustep_evt;
	endproperty
	a_double: assert property (p_double) else $error("fall lost");
	property p_burst;
		$rose(step_in) && step_interp_enable && step_mode_active
			|-> ##[3:6] ustep_evt ##G ustep_evt;
	endproperty
	a_burst: assert property (p_burst) else $error("no burst");
	property p_inc;
		ustep_evt && !step_interp_enable && !dir_in
			|-> ustep_pos == 10'($past(ustep_pos) + inc);
	endproperty
	a_inc: assert property (p_inc) else $error("bad increment");
	property p_blank;
		$fell(blank_active)
			|-> blen inside {7'h10, 7'h18, 7'h24, 7'h36};
	endproperty
	a_blank: assert property (p_blank) else $error("bad blank");
	property p_blank_on;
		blank_active |-> bridge_on;
	endproperty
	a_blank_on: assert property (p_blank_on) else $error("blank off");
	property p_fast;
		$rose(fast_decay) |-> $past(bridge_on) && chopper_mode_select;
	endproperty
	a_fast: assert property (p_fast) else $error("fast misplaced");
	c_sub: cover property (ustep_evt && step_interp_enable);
	c_fast: cover property ($rose(fast_decay));
	c_blank: cover property ($fell(blank_active));
endmodule
bind stp_drv stp_drv_props #(.INTERP_GAP(INTERP_GAP)) stp_drv_props_i (
	.sys_clk, .rst_n, .step_in, .dir_in, .step_mode_active,
	.step_interp_enable, .double_edge_step, .microstep_resolution,
	.ustep_pos, .ustep_evt, .chopper_mode_select, .bridge_on,
	.fast_decay, .slow_decay, .blank_active
);
`default_nettype wire

//--- sim/stp_drv_test.sv
// Purpose: self-checking bench for stp_drv
// Assumes: controller model owns serial and step pins
// Notes: INTERP_GAP cut to 2 to keep bursts short
`timescale 1ns/1ps
`default_nettype none
module stp_drv_test;
	logic       sys_clk, rst_n, spi_sck, spi_cs_n, spi_sdi;
	logic       step_in, dir_in, peak_in, neg_in, nr;
	logic       step_mode_active, step_interp_enable, double_edge_step;
	logic [3:0] microstep_resolution;
	logic [9:0] ustep_pos, p0;
	logic       ustep_evt, chopper_mode_select, bridge_on, fast_decay;
	logic       slow_decay, blank_active, hyst_dec_tick;
	int         n_mismatch, samples_checked, len, i, k, nevt;
	int         bl[4] = '{16, 24, 36, 54};
	stp_drv #(.INTERP_GAP(2)) stp_drv_i (
		.sys_clk, .rst_n, .spi_sck, .spi_cs_n, .spi_sdi, .step_in, .dir_in,
		.peak_in, .neg_in, .step_mode_active, .step_interp_enable,
		.double_edge_step, .microstep_resolution, .ustep_pos, .ustep_evt,
		.chopper_mode_select, .bridge_on, .fast_decay, .slow_decay,
		.blank_active, .hyst_dec_tick
	);
	stp_ctl_model stp_ctl_model_i (
		.sys_clk, .spi_sck, .spi_cs_n, .spi_sdi, .step_in, .dir_in
	);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (ustep_evt === 1'b1)
			nevt++;
	// ==========================================================
	// helpers
	function automatic logic [19:0] dw(logic ip, de, logic [3:0] m);
		return {2'b00, 8'h00, ip, de, 4'h0, m};
	endfunction
	function automatic logic [19:0] cw(logic [1:0] t, logic c, r,
		logic [1:0] h, logic [3:0] f);
		return {3'b100, t, c, r, h, 4'h0, 3'h1, f};
	endfunction
	function automatic logic pick(int s);
		case (s)
			0: return blank_active;
			1: return fast_decay;
			2: return slow_decay;
			default: return !hyst_dec_tick;
		endcase
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [9:0] got, logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	// skip the running phase, wait for the next, count its cycles
	task automatic meas(int s, output int n);
		int t;
		t = 0;
		n = 0;
		for (int ph = 0; ph < 3; ph++)
			while (pick(s) === (ph != 1) && t < 900) begin
				@(posedge sys_clk);
				#1;
				t++;
				n += (ph == 2);
				if (n == 2 && s == 1)
					neg_in = nr;
			end
		if (t >= 900) begin
			chk("wait", 10'h000, 10'h001);
			finish_test;
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		peak_in = 1'b1;
		neg_in = 1'b0;
		nr = 1'b0;
		nevt = 0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		chk("mode", step_mode_active, 10'h001);
		chk("pos", ustep_pos, 10'h000);
		for (k = 0; k <= 8; k++) begin
			stp_ctl_model_i.send(dw(1'b0, 1'b0, 4'(k)));
			chk("microstep_resolution", microstep_resolution, 10'(k));
			p0 = ustep_pos;
			stp_ctl_model_i.pulse(1'b0, 10);
			stp_ctl_model_i.pulse(1'b0, 10);
			chk("pos", ustep_pos, 10'(p0 + (10'h001 << k)));
		end
		$display("test resolution done");
		stp_ctl_model_i.send(dw(1'b1, 1'b0, 4'h4));
		chk("interp en", step_interp_enable, 10'h001);
		p0 = ustep_pos;
		i = nevt;
		stp_ctl_model_i.pulse(1'b0, 70);
		stp_ctl_model_i.pulse(1'b0, 10);
		chk("interp", ustep_pos, 10'(p0 + 10'h010));
		chk("subs", 10'(nevt - i), 10'h010);
		stp_ctl_model_i.send(dw(1'b0, 1'b1, 4'h8));
		p0 = ustep_pos;
		stp_ctl_model_i.pulse(1'b1, 10);
		stp_ctl_model_i.pulse(1'b1, 10);
		chk("double_edge_step", ustep_pos, 10'(p0 - 10'h200));
		$display("test step modes done");
		stp_ctl_model_i.send(20'hE0080);
		chk("mode", step_mode_active, 10'h000);
		p0 = ustep_pos;
		stp_ctl_model_i.pulse(1'b0, 10);
		chk("idle", ustep_pos, p0);
		stp_ctl_model_i.send(20'hE0000);
		chk("mode", step_mode_active, 10'h001);
		$display("test step disable done");
		for (k = 0; k < 4; k++) begin
			stp_ctl_model_i.send(cw(2'(k), 1'b0, 1'b0, 2'(k), 4'h1));
			meas(0, len);
			chk("blank", 10'(len), 10'(bl[k]));
			chk("on", bridge_on, 10'h001);
			meas(3, len);
			chk("hyst_decrement_sel", 10'(len), 10'(16 * k + 15));
		end
		chk("keep", double_edge_step, 10'h001);
		meas(2, len);
		chk("slow", 10'(len), 10'h02C);
		stp_ctl_model_i.send(cw(2'h0, 1'b0, 1'b1, 2'h0, 4'h1));
		i = 0;
		for (k = 0; k < 4; k++) begin
			meas(2, len);
			chk("rnd", 10'(len >= 32 && len <= 47), 10'h001);
			i += (len != 44);
		end
		chk("rnd vary", 10'(i > 0), 10'h001);
		$display("test standard chopper done");
		for (k = 0; k < 3; k++) begin
			neg_in = 1'b0;
			nr = (k > 0);
			stp_ctl_model_i.send(cw(2'h0, 1'b1, 1'b0, 2'(k), 4'h1));
			chk("chm", chopper_mode_select, 10'h001);
			meas(1, len);
			chk("fast", 10'(k == 1 ? len < 10 : len == 32), 10'h001);
		end
		$display("test constant chopper done");
		finish_test;
	end
endmodule
`default_nettype wire
